// >>> hdl/sbsc_sync.sv
// Shared constants for the boundary scan chain, plus the two-flop level synchroniser.
// Notes on behaviour
// - Two memory clock edges in a row with scan clock and enable low restore normal operation.
// - First scan clock rise after normal operation captures all pin levels in parallel.
// - With scan enable high, each scan clock fall shifts one cell toward output.
// - Scan clock toggling with scan enable low is bypass; input sampled on rises.
// - In bypass, the sampled bit appears on the output at the next fall.
// - Fixed bit order: address 6,4,2,0, data pairs, address, data pairs, address, then controls and clock.
// - Capture and shifting only observe pins and never disturb the memory.
// - The chain has 41 cells; supplies, unconnected and scan pins excluded.
`timescale 1ns/1ps
`default_nettype none

package sbsc_pkg;
  localparam int ADDR_W    = 19;
  localparam int WORD_W    = 9;
  localparam int CHAIN_LEN = 41;
  localparam int IDX_W     = 6;

  // Bit positions of each pin inside the packed pin vector.
  localparam int LOC_BASE  = 0;
  localparam int IN_BASE   = 19;
  localparam int OUT_BASE  = 28;
  localparam int CE_POS    = 37;
  localparam int OE_POS    = 38;
  localparam int WE_POS    = 39;
  localparam int CLK_POS   = 40;

  typedef logic [IDX_W-1:0] sbsc_idx_t;

  typedef enum logic [1:0] {
    SBSC_NORMAL = 2'b00,
    SBSC_SCAN   = 2'b01,
    SBSC_BYPASS = 2'b10
  } sbsc_mode_e;

  // Entry 0 leaves the serial output first.
  localparam sbsc_idx_t SCAN_ORDER [CHAIN_LEN] = '{
    sbsc_idx_t'(LOC_BASE + 6), sbsc_idx_t'(LOC_BASE + 4), sbsc_idx_t'(LOC_BASE + 2),
    sbsc_idx_t'(LOC_BASE + 0), sbsc_idx_t'(IN_BASE + 8), sbsc_idx_t'(OUT_BASE + 8),
    sbsc_idx_t'(IN_BASE + 6), sbsc_idx_t'(OUT_BASE + 6), sbsc_idx_t'(IN_BASE + 4),
    sbsc_idx_t'(OUT_BASE + 4), sbsc_idx_t'(IN_BASE + 2), sbsc_idx_t'(OUT_BASE + 2),
    sbsc_idx_t'(IN_BASE + 0), sbsc_idx_t'(OUT_BASE + 0), sbsc_idx_t'(LOC_BASE + 18),
    sbsc_idx_t'(LOC_BASE + 1), sbsc_idx_t'(LOC_BASE + 3), sbsc_idx_t'(LOC_BASE + 5),
    sbsc_idx_t'(LOC_BASE + 7), sbsc_idx_t'(LOC_BASE + 8), sbsc_idx_t'(LOC_BASE + 9),
    sbsc_idx_t'(LOC_BASE + 10), sbsc_idx_t'(LOC_BASE + 11), sbsc_idx_t'(LOC_BASE + 12),
    sbsc_idx_t'(LOC_BASE + 13), sbsc_idx_t'(OUT_BASE + 1), sbsc_idx_t'(IN_BASE + 1),
    sbsc_idx_t'(OUT_BASE + 3), sbsc_idx_t'(IN_BASE + 3), sbsc_idx_t'(OUT_BASE + 5),
    sbsc_idx_t'(IN_BASE + 5), sbsc_idx_t'(OUT_BASE + 7), sbsc_idx_t'(IN_BASE + 7),
    sbsc_idx_t'(LOC_BASE + 15), sbsc_idx_t'(LOC_BASE + 16), sbsc_idx_t'(LOC_BASE + 14),
    sbsc_idx_t'(LOC_BASE + 17), sbsc_idx_t'(CE_POS), sbsc_idx_t'(OE_POS),
    sbsc_idx_t'(WE_POS), sbsc_idx_t'(CLK_POS)
  };
endpackage : sbsc_pkg

module sbsc_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output var  logic q
);
  logic stage;
  logic next_stage;
  logic next_q;

  // The first stage feeds only the second stage.
  always_comb begin
    next_stage = rst ? 1'b0 : d;
    next_q     = rst ? 1'b0 : stage;
  end

  always_ff @(posedge clk) begin
    stage <= next_stage;
    q     <= next_q;
  end
endmodule // sbsc_sync

`default_nettype wire

// >>> hdl/sbsc_chain.sv
// Boundary scan chain of the synchronous RAM: capture, shift and bypass paths.
`timescale 1ns/1ps
`default_nettype none

module sbsc_chain
  import sbsc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] location_bits,
  input  wire logic [WORD_W-1:0] input_word,
  input  wire logic [WORD_W-1:0] output_word,
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic              scan_clk,
  input  wire logic              capture_block_n,
  input  wire logic              serial_in,
  output var  logic              serial_out,
  output var  logic              ram_normal
);

  // ---------------- Memory clock domain ----------------
  logic                 sck_s;
  logic                 se_s;
  logic                 clk_phase;
  logic [CHAIN_LEN-1:0] pin_reg;
  logic [CHAIN_LEN-1:0] snap;
  logic                 entry_tgl;
  logic                 next_clk_phase;
  logic [CHAIN_LEN-1:0] next_pin_reg;
  logic [CHAIN_LEN-1:0] next_snap;
  logic                 next_entry_tgl;
  logic                 next_ram_normal;
  logic                 scan_idle;
  logic                 se;
  logic                 idle_prev;
  logic                 next_idle_prev;
  logic                 pins_quiet;

  // The scan enable pin is carried inverted: low blocks further capture.
  assign se = ~capture_block_n;

  sbsc_sync u_sync_sck (
    .clk (clk),
    .rst (rst),
    .d   (scan_clk),
    .q   (sck_s)
  );

  sbsc_sync u_sync_se (
    .clk (clk),
    .rst (rst),
    .d   (se),
    .q   (se_s)
  );

  assign scan_idle = ~sck_s & ~se_s;

  // A single idle sample may fall inside a scan clock low phase of bypass or
  // capture; only two idle samples in a row mean the tester has parked the pins.
  assign pins_quiet = scan_idle & idle_prev;

  always_comb begin
    next_clk_phase  = ~clk_phase;
    next_idle_prev  = scan_idle;
    // Input registers are only read here; nothing is fed back to the array.
    next_pin_reg    = {clk_phase, we_n, oe_n, ce_n, output_word, input_word,
                       location_bits};
    // The snapshot freezes once scan activity is seen, so the scan side may
    // read it as a quasi-static word without a per-bit crossing.
    next_snap       = pins_quiet ? pin_reg : snap;
    next_ram_normal = pins_quiet;
    next_entry_tgl  = entry_tgl ^ (pins_quiet & ~ram_normal);
    if (rst) begin
      next_clk_phase  = 1'b0;
      next_idle_prev  = 1'b1;
      next_pin_reg    = '0;
      next_snap       = '0;
      next_ram_normal = 1'b1;
      next_entry_tgl  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    clk_phase  <= next_clk_phase;
    idle_prev  <= next_idle_prev;
    pin_reg    <= next_pin_reg;
    snap       <= next_snap;
    ram_normal <= next_ram_normal;
    entry_tgl  <= next_entry_tgl;
  end

  // ---------------- Scan clock domain ----------------
  logic                 srst;
  logic                 entry_s;
  logic                 entry_seen;
  logic                 cap_tgl;
  logic                 cap_seen;
  logic                 bypass_bit;
  sbsc_mode_e           mode;
  logic [CHAIN_LEN-1:0] chain;
  logic [CHAIN_LEN-1:0] ordered;
  logic                 pending;
  logic                 load;
  logic                 next_entry_seen;
  logic                 next_cap_tgl;
  logic                 next_bypass_bit;
  sbsc_mode_e           next_mode;
  logic                 next_cap_seen;
  logic [CHAIN_LEN-1:0] next_chain;
  logic                 next_serial_out;

  // The scan clock stands still while reset is released and while the entry
  // toggle moves, so both are read as quasi-static levels; a flop chain on a
  // stopped clock would only settle two rises late and miss the capture.
  assign srst    = rst;
  assign entry_s = entry_tgl;

  genvar gi;
  generate
    for (gi = 0; gi < CHAIN_LEN; gi++) begin : g_order
      assign ordered[gi] = snap[SCAN_ORDER[gi]];
    end
  endgenerate

  // A fresh return to normal operation arms one capture on the next rise.
  assign pending = entry_s ^ entry_seen;
  assign load    = cap_tgl ^ cap_seen;

  always_comb begin
    next_entry_seen = entry_s;
    next_cap_tgl    = cap_tgl ^ pending;
    next_bypass_bit = bypass_bit;
    next_mode       = mode;
    case (mode)
      SBSC_NORMAL, SBSC_SCAN, SBSC_BYPASS: begin
        if (pending) begin
          next_mode = SBSC_SCAN;
        end else if (!se) begin
          next_bypass_bit = serial_in;
          next_mode       = SBSC_BYPASS;
        end
      end
      default: next_mode = SBSC_NORMAL;
    endcase
    if (srst) begin
      next_entry_seen = 1'b0;
      next_cap_tgl    = 1'b0;
      next_bypass_bit = 1'b0;
      next_mode       = SBSC_NORMAL;
    end
  end

  always_ff @(posedge scan_clk) begin
    entry_seen <= next_entry_seen;
    cap_tgl    <= next_cap_tgl;
    bypass_bit <= next_bypass_bit;
    mode       <= next_mode;
  end

  // The parallel load is completed on the fall that follows the capturing
  // rise; the chain then lives on falling edges only, avoiding dual-edge flops.
  always_comb begin
    next_cap_seen   = cap_tgl;
    next_chain      = chain;
    next_serial_out = serial_out;
    if (load) begin
      next_chain      = {serial_in, ordered[CHAIN_LEN-1:1]};
      next_serial_out = ordered[0];
    end else if (se) begin
      next_chain      = {serial_in, chain[CHAIN_LEN-1:1]};
      next_serial_out = chain[0];
    end else begin
      next_serial_out = bypass_bit;
    end
    if (srst) begin
      next_cap_seen   = 1'b0;
      next_chain      = '0;
      next_serial_out = 1'b0;
    end
  end

  always_ff @(negedge scan_clk) begin
    cap_seen   <= next_cap_seen;
    chain      <= next_chain;
    serial_out <= next_serial_out;
  end

  // ---------------- Checks ----------------
  sequence s_bypass_rise;
    !pending && !se;
  endsequence

  sequence s_shift_fall;
    !load && se;
  endsequence

  a_normal_resume: assert property (@(posedge clk) disable iff (rst)
    (!sck_s && !se_s && !$past(sck_s) && !$past(se_s)) |=> ram_normal)
    else $error("normal operation not restored after idle scan pins");

  a_idle_filter: assert property (@(posedge clk) disable iff (rst)
    (!sck_s && !se_s && ($past(sck_s) || $past(se_s))) |=> !ram_normal)
    else $error("one idle sample restored normal operation");

  a_normal_leave: assert property (@(posedge clk) disable iff (rst)
    (sck_s || se_s) |=> !ram_normal ##0 $stable(snap))
    else $error("normal flag or snapshot moved during scan activity");

  a_pin_observe: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> pin_reg[ADDR_W-1:0] == $past(location_bits))
    else $error("input register does not follow the address pins");

  a_capture_arm: assert property (@(posedge scan_clk) disable iff (srst)
    pending |=> mode == SBSC_SCAN && cap_tgl != $past(cap_tgl))
    else $error("capture not taken on first scan rise");

  a_capture_out: assert property (@(negedge scan_clk) disable iff (srst)
    load |=> serial_out == $past(ordered[0]) && !load)
    else $error("first captured bit not presented");

  a_shift_step: assert property (@(negedge scan_clk) disable iff (srst)
    s_shift_fall |=> serial_out == $past(chain[0]) && chain[0] == $past(chain[1]))
    else $error("chain did not shift by one cell");

  a_serial_enter: assert property (@(negedge scan_clk) disable iff (srst)
    s_shift_fall |=> chain[CHAIN_LEN-1] == $past(serial_in))
    else $error("serial input did not enter the first cell");

  a_bypass_sample: assert property (@(posedge scan_clk) disable iff (srst)
    s_bypass_rise |=> bypass_bit == $past(serial_in) && mode == SBSC_BYPASS)
    else $error("bypass did not sample the serial input");

  a_bypass_path: assert property (@(negedge scan_clk) disable iff (srst)
    (!load && !se) |=> serial_out == $past(bypass_bit))
    else $error("bypass bit not driven on the falling edge");

endmodule // sbsc_chain

`default_nettype wire

// >>> sim/sbsc_tester.sv
// Board test controller model that drives the scan pins of the chain.
`timescale 1ns/1ps
`default_nettype none

module sbsc_tester (
  output var  logic scan_clk,
  output var  logic capture_block_n,
  output var  logic serial_in,
  input  wire logic serial_out
);
  initial begin
    scan_clk        = 1'b0;
    capture_block_n = 1'b1;
    serial_in       = 1'b0;
  end

  // One 125 ns scan period; the low phase is kept short so no memory clock pair fits in it.
  task automatic tick(input logic se, input logic bit_in, output logic seen);
    capture_block_n = !se;
    serial_in       = bit_in;
    #15 scan_clk    = 1'b1;
    #80 scan_clk    = 1'b0;
    #21 seen        = serial_out;
    // A released data line must not keep showing its last level.
    serial_in       = !bit_in;
    #9;
  endtask

  task automatic park();
    scan_clk        = 1'b0;
    capture_block_n = 1'b1;
  endtask
endmodule // sbsc_tester
`default_nettype wire

// >>> sim/sbsc_chain_bench.sv
// Self-checking bench for the boundary scan chain driven by the tester model.
`timescale 1ns/1ps
`default_nettype none

module sbsc_chain_bench
  import sbsc_pkg::*;
;
  logic              clk;
  logic              rst;
  logic [ADDR_W-1:0] location_bits;
  logic [WORD_W-1:0] input_word;
  logic [WORD_W-1:0] output_word;
  logic              ce_n;
  logic              oe_n;
  logic              we_n;
  logic              dummy;
  wire               scan_clk;
  wire               capture_block_n;
  wire               serial_in;
  wire               serial_out;
  wire               ram_normal;
  int                bad_count = 0;
  int                tests_run = 0;
  int                cycles = 0;

  sbsc_chain dut_u (
    .clk(clk), .rst(rst), .location_bits(location_bits), .input_word(input_word),
    .output_word(output_word), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .scan_clk(scan_clk), .capture_block_n(capture_block_n), .serial_in(serial_in),
    .serial_out(serial_out), .ram_normal(ram_normal)
  );

  sbsc_tester tester_u (
    .scan_clk(scan_clk), .capture_block_n(capture_block_n),
    .serial_in(serial_in), .serial_out(serial_out)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic t_normal();
    wait_clk(4);
    chk_bit(ram_normal, 1'b1);
    $display("Test normal done");
  endtask

  task automatic t_scan(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                        input logic [WORD_W-1:0] q, input logic [2:0] ctl);
    logic [39:0] exp;
    logic [7:0]  feed;
    logic        seen;
    feed = 8'h9d;
    location_bits = a;
    input_word = d;
    output_word = q;
    {ce_n, oe_n, we_n} = ctl;
    exp = {a[6], a[4], a[2], a[0], d[8], q[8], d[6], q[6], d[4], q[4], d[2], q[2], d[0], q[0],
           a[18], a[1], a[3], a[5], a[7], a[8], a[9], a[10], a[11], a[12], a[13], q[1], d[1],
           q[3], d[3], q[5], d[5], q[7], d[7], a[15], a[16], a[14], a[17], ctl};
    // The pins must have settled into the snapshot before the capturing rise.
    wait_clk(5);
    tester_u.tick(1'b0, feed[0], seen);
    chk_bit(seen, exp[39]);
    // The clock cell is not predictable, so bit 40 is not judged.
    for (int k = 1; k < 45; k++) begin
      tester_u.tick(1'b1, feed[k % 8], seen);
      if (k < 40) chk_bit(seen, exp[39-k]);
      else if (k > 40) chk_bit(seen, feed[(k-41) % 8]);
    end
    chk_bit(ram_normal, 1'b0);
    for (int k = 0; k < 4; k++) begin
      tester_u.tick(1'b0, feed[k], seen);
      chk_bit(seen, feed[k]);
    end
    tester_u.park();
    #100;
    wait_clk(4);
    chk_bit(ram_normal, 1'b1);
    $display("Test scan done");
  endtask

  initial begin
    rst = 1'b1;
    location_bits = '0;
    input_word = '0;
    output_word = '0;
    {ce_n, oe_n, we_n} = 3'h7;
    // The scan side reset is not synchronised but only acts on scan clock edges, so its clock runs during reset.
    fork
      repeat (4) tester_u.tick(1'b0, 1'b0, dummy);
      repeat (12) @(posedge clk);
    join
    #2 rst = 1'b0;
    t_normal();
    t_scan(19'h5a3c6, 9'h1b4, 9'h0c9, 3'h5);
    t_scan(19'h25c39, 9'h04b, 9'h136, 3'h2);
    end_sim();
  end
endmodule // sbsc_chain_bench
`default_nettype wire
